// >>> btf_pkg.sv
package btf_pkg;
   localparam logic [1:0] ADR_EVENT_FLAGS = 2'h0;
   localparam logic [1:0] ADR_EVENT_ENABLES = 2'h1;
   localparam logic [1:0] ADR_LINE_STATUS = 2'h2;
   localparam logic [15:0] EVENT_FLAGS_RST = 16'h0000;
   localparam logic [15:0] EVENT_ENABLES_RST = 16'h0000;
   localparam logic [15:0] EVENT_USED_MASK = 16'h1C9F;
   localparam int EV_RX_BUF = 0;
   localparam int EV_SENT_BUF = 1;
   localparam int EV_NO_BUFFER = 2;
   localparam int EV_CHAR_RCVD = 3;
   localparam int EV_TX_ERROR = 4;
   localparam int EV_HALT_DONE = 7;
   localparam int EV_CS_CHANGED = 10;
   localparam int EV_TX_GLITCH = 11;
   localparam int EV_RX_GLITCH = 12;
   localparam int LS_CARRIER = 0;
   localparam logic [15:0] CRC16_POLY_REFL = 16'hA001;
   typedef enum logic [3:0] {
      S_IDLE, S_PRE, S_DATA, S_DUP, S_END, S_CK0, S_CK1, S_CLOSE, S_SYN1, S_SYN2, S_FILL
   } btf_state_t;
   typedef struct packed {
      btf_state_t st;
      logic [15:0] cnt;
      logic eom;
      logic tb;
      logic cm;
      logic inc;
      logic tr;
      logic [15:0] chk;
      logic in_msg;
      logic stop;
      logic starved;
      logic lost;
      logic fill_dle;
      logic [7:0] hold;
      logic hold_v;
      logic [15:0] ev;
      logic [15:0] en;
      logic cs;
      logic rx_wait;
      logic [15:0] rdata;
      logic cls;
      logic cls_keep;
   } btf_regs_t;
endpackage : btf_pkg

// >>> btf_tx_framer.sv
`timescale 1ns/1ps
module btf_tx_framer (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   input wire logic desc_ready,
   input wire logic desc_eom,
   input wire logic desc_send_check_after,
   input wire logic desc_continuous_reuse,
   input wire logic desc_check_accum_reset,
   input wire logic desc_prepend_escape,
   input wire logic desc_clear_channel_mode,
   input wire logic desc_check_include,
   input wire logic [15:0] desc_length,
   output logic desc_take,
   output logic desc_close,
   output logic desc_keep_ready,
   output logic desc_starved_flag,
   output logic desc_send_permit_lost,
   input wire logic [7:0] data_byte,
   input wire logic data_valid,
   output logic data_ready,
   output logic [7:0] line_char,
   output logic line_valid,
   input wire logic line_ready,
   input wire logic cts,
   input wire logic [7:0] sync_char,
   input wire logic [7:0] dle_char,
   input wire logic lrc_select,
   input wire logic idle_fill_select,
   input wire logic [15:0] tx_check_preset,
   input wire logic graceful_stop,
   input wire logic restart_tx,
   input wire logic carrier_sense,
   input wire logic rx_clock_glitch,
   input wire logic tx_clock_glitch,
   input wire logic rx_char_stored,
   input wire logic rx_discard,
   input wire logic rx_buffer_closed,
   input wire logic enter_hunt,
   output logic rx_suspended,
   output logic irq
);
   import btf_pkg::*;

   // ----------------------------------------
   // Check accumulation
   // ----------------------------------------
   function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC16_POLY_REFL) : (r >> 1);
      end
      return r;
   endfunction : crc16_byte

   // Longitudinal check only outside transparent mode
   function automatic logic [15:0] accum(input logic [15:0] c, input logic [7:0] b,
                                         input logic lrc, input logic tr);
      return (lrc && !tr) ? {8'h00, c[7:0] ^ b} : crc16_byte(c, b);
   endfunction : accum

   btf_regs_t q, d;
   logic ld;
   logic [15:0] ev_set;
   logic [15:0] ev_clr;

   assign ld = !q.hold_v || line_ready;
   assign line_char = q.hold;
   assign line_valid = q.hold_v;
   assign reg_rdata = q.rdata;
   assign desc_close = q.cls;
   assign desc_keep_ready = q.cls_keep;
   assign desc_starved_flag = q.starved;
   assign desc_send_permit_lost = q.lost;
   assign rx_suspended = q.rx_wait;
   assign irq = |(q.ev & q.en);
   assign desc_take = (q.st == S_IDLE) && !q.stop && desc_ready;
   assign data_ready = (q.st == S_DATA) && ld;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      d = q;
      d.cls = 1'b0;
      d.cls_keep = 1'b0;
      ev_set = '0;
      if (ld) begin
         d.hold_v = 1'b0;
      end
      if (!cts && q.st != S_IDLE && q.st != S_FILL && q.st != S_SYN1 && q.st != S_SYN2) begin
         d.lost = 1'b1;
      end
      unique case (q.st)
         S_IDLE: begin
            if (desc_take) begin
               d.eom = desc_eom;
               d.tb = desc_eom && desc_send_check_after;
               d.cm = desc_continuous_reuse;
               d.inc = desc_check_include;
               d.tr = desc_clear_channel_mode;
               d.cnt = desc_length;
               d.in_msg = 1'b1;
               d.starved = 1'b0;
               d.lost = !cts;
               if (desc_check_accum_reset) begin
                  d.chk = tx_check_preset;
               end
               d.st = desc_prepend_escape ? S_PRE : S_DATA;
            end
         end
         S_PRE: begin
            if (ld) begin
               d.hold = dle_char;
               d.hold_v = 1'b1;
               d.st = S_DATA;
            end
         end
         S_DATA: begin
            if (ld && data_valid) begin
               d.hold = data_byte;
               d.hold_v = 1'b1;
               d.cnt = q.cnt - 16'h0001;
               if (q.inc) begin
                  d.chk = accum(q.chk, data_byte, lrc_select, q.tr);
               end
               if (q.tr && data_byte == dle_char) begin
                  d.st = S_DUP;
               end else if (q.cnt == 16'h0001) begin
                  d.st = S_END;
                  ev_set[EV_SENT_BUF] = !q.tb;
               end
            end
         end
         S_DUP: begin
            if (ld) begin
               d.hold = dle_char;
               d.hold_v = 1'b1;
               d.st = (q.cnt == 16'h0000) ? S_END : S_DATA;
               ev_set[EV_SENT_BUF] = (q.cnt == 16'h0000) && !q.tb;
            end
         end
         S_END: begin
            if (!q.eom && !desc_ready) begin
               d.starved = 1'b1;
            end
            d.st = q.tb ? S_CK0 : S_CLOSE;
         end
         S_CK0: begin
            if (ld) begin
               d.hold = q.chk[7:0];
               d.hold_v = 1'b1;
               if (lrc_select && !q.tr) begin
                  ev_set[EV_SENT_BUF] = 1'b1;
                  d.chk = tx_check_preset;
                  d.st = S_CLOSE;
               end else begin
                  d.st = S_CK1;
               end
            end
         end
         S_CK1: begin
            if (ld) begin
               d.hold = q.chk[15:8];
               d.hold_v = 1'b1;
               ev_set[EV_SENT_BUF] = 1'b1;
               d.chk = tx_check_preset;
               d.st = S_CLOSE;
            end
         end
         S_CLOSE: begin
            d.cls = 1'b1;
            d.cls_keep = q.cm && !q.starved && !q.lost;
            ev_set[EV_TX_ERROR] = q.starved || q.lost;
            d.in_msg = !q.eom;
            d.fill_dle = 1'b0;
            if (q.starved) begin
               d.st = S_FILL;
            end else if (q.eom && !q.tb && !idle_fill_select) begin
               d.st = S_SYN1;
            end else begin
               d.st = S_IDLE;
            end
            if (q.eom) begin
               d.tr = 1'b0;
            end
         end
         S_SYN1, S_SYN2: begin
            if (ld) begin
               d.hold = sync_char;
               d.hold_v = 1'b1;
               d.st = (q.st == S_SYN1) ? S_SYN2 : S_IDLE;
            end
         end
         S_FILL: begin
            // Pairs are never split, so a new buffer starts on a clean boundary
            if (ld) begin
               d.hold_v = 1'b1;
               if (q.tr && !q.fill_dle) begin
                  d.hold = dle_char;
                  d.fill_dle = 1'b1;
               end else begin
                  d.hold = sync_char;
                  d.fill_dle = 1'b0;
                  if (desc_ready) begin
                     d.st = S_IDLE;
                  end
               end
            end
         end
         default: d.st = S_IDLE;
      endcase

      // Graceful stop holds off new descriptors until restart
      if (graceful_stop) begin
         d.stop = 1'b1;
      end
      if (restart_tx) begin
         d.stop = 1'b0;
      end
      ev_set[EV_HALT_DONE] = q.stop && q.in_msg && !d.in_msg ||
                             graceful_stop && !q.stop && !q.in_msg;
      ev_set[EV_RX_GLITCH] = rx_clock_glitch;
      ev_set[EV_TX_GLITCH] = tx_clock_glitch;
      ev_set[EV_CS_CHANGED] = carrier_sense != q.cs;
      ev_set[EV_CHAR_RCVD] = rx_char_stored;
      ev_set[EV_NO_BUFFER] = rx_discard;
      ev_set[EV_RX_BUF] = rx_buffer_closed;
      d.cs = carrier_sense;
      if (rx_discard) begin
         d.rx_wait = 1'b1;
      end else if (enter_hunt) begin
         d.rx_wait = 1'b0;
      end

      // ----------------------------------------
      // Register file
      // ----------------------------------------
      ev_clr = (reg_wr && reg_addr == ADR_EVENT_FLAGS) ? reg_wdata : 16'h0000;
      d.ev = ((q.ev & ~ev_clr) | ev_set) & EVENT_USED_MASK;
      if (reg_wr && reg_addr == ADR_EVENT_ENABLES) begin
         d.en = reg_wdata & EVENT_USED_MASK;
      end
      unique case (reg_addr)
         ADR_EVENT_FLAGS: d.rdata = q.ev;
         ADR_EVENT_ENABLES: d.rdata = q.en;
         ADR_LINE_STATUS: d.rdata = {15'h0000, q.cs};
         default: d.rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.st <= S_IDLE;
         q.ev <= EVENT_FLAGS_RST;
         q.en <= EVENT_ENABLES_RST;
      end else if (ce) begin
         q <= d;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   ev_set_wins_a: assert property (ce && ev_set[EV_TX_ERROR] |=> q.ev[EV_TX_ERROR])
      else $error("tx error event lost");
   w1c_clear_a: assert property (ce && reg_wr && reg_addr == ADR_EVENT_FLAGS && reg_wdata[0]
      && !rx_buffer_closed |=> !q.ev[EV_RX_BUF])
      else $error("write one did not clear");
   w0_keeps_a: assert property (ce && q.ev[EV_CHAR_RCVD] && reg_wr && reg_addr == ADR_EVENT_FLAGS
      && !reg_wdata[EV_CHAR_RCVD] |=> q.ev[EV_CHAR_RCVD])
      else $error("write zero changed a flag");
   reserved_zero_a: assert property ((q.ev & ~EVENT_USED_MASK) == 16'h0000)
      else $error("reserved event bit set");
   irq_hold_a: assert property ((q.ev & q.en) != 16'h0000 |-> irq)
      else $error("irq dropped with enabled event");
   dle_double_a: assert property (ce && q.st == S_DATA && ld && data_valid && q.tr
      && data_byte == dle_char |=> q.st == S_DUP)
      else $error("dle not doubled");
   prepend_a: assert property (ce && desc_take && desc_prepend_escape ##1 ce && ld
      |=> line_char == dle_char && line_valid)
      else $error("escape not prepended");
   preset_a: assert property (ce && desc_take && desc_check_accum_reset
      |=> q.chk == $past(tx_check_preset))
      else $error("check not reset");
   keep_ready_a: assert property (q.cls && (q.starved || q.lost) |-> !desc_keep_ready)
      else $error("ready kept after error");
   starve_txe_a: assert property (ce && q.cls && q.starved |=> q.ev[EV_TX_ERROR])
      else $error("starved without tx error");
   cs_change_a: assert property (ce && carrier_sense != q.cs |=> q.ev[EV_CS_CHANGED])
      else $error("carrier change missed");
   halt_now_a: assert property (ce && graceful_stop && !q.stop && !q.in_msg
      |=> q.ev[EV_HALT_DONE])
      else $error("halt not immediate");

   underrun_c: cover property (q.st == S_FILL && q.tr ##[1:20] q.st == S_IDLE);
   check_sent_c: cover property (q.st == S_CK1 ##1 q.st == S_CLOSE);
   reuse_c: cover property (q.cls && desc_keep_ready);
   halt_late_c: cover property (q.stop && q.in_msg ##[1:50] q.ev[EV_HALT_DONE]);
endmodule : btf_tx_framer

// >>> btf_line_station.sv
`timescale 1ns/1ps
// ------------------------------
// Remote station on the line
// ------------------------------
module btf_line_station (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic [7:0] line_char,
   input wire logic line_valid,
   output logic line_ready
);
   logic [7:0] got_q [$];
   logic [1:0] gap_q;
   // Slow mode takes one char in four, so the framer must hold its char
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gap_q <= 2'h0;
      end else begin
         gap_q <= gap_q + 2'h1;
         if (line_valid && line_ready) begin
            got_q.push_back(line_char);
         end
      end
   end
   assign line_ready = !slow || (gap_q == 2'h3);
endmodule : btf_line_station

// >>> tb_top.sv
`timescale 1ns/1ps
// ------------------------------
// Framer bench
// ------------------------------
module tb_top;
   import btf_pkg::*;
   typedef struct packed {
      logic eom, tb, cm, br, td, tr, inc, lrc, slow;
      logic [3:0] len;
      logic [7:0] b0;
   } btf_row_t;
   localparam logic [7:0] SYNC = 8'h33;
   localparam logic [7:0] DLE = 8'h55;
   logic sys_clk, rst, reg_wr, desc_ready, desc_take, desc_close, desc_keep_ready, irq;
   logic desc_eom, desc_send_check_after, desc_continuous_reuse, desc_check_accum_reset;
   logic desc_prepend_escape, desc_clear_channel_mode, desc_check_include, lrc_select, slow;
   logic desc_starved_flag, desc_send_permit_lost, data_ready, line_valid, line_ready, cts;
   logic graceful_stop, restart_tx, carrier_sense, rx_clock_glitch, tx_clock_glitch;
   logic rx_char_stored, rx_discard, rx_buffer_closed, enter_hunt, rx_suspended;
   logic data_valid = 1'b0;
   logic idle_fill;
   logic [1:0] reg_addr;
   logic [7:0] pv, data_byte, line_char;
   logic [15:0] reg_wdata, reg_rdata, desc_length, acc;
   logic [7:0] src [16];
   logic [7:0] exp_q [$];
   int src_idx, src_len, fails, n_checks;
   btf_row_t rows [5] = '{{9'b110100100, 4'h3, 8'h10}, {9'b101110101, 4'h1, 8'h40},
      {9'b110000100, 4'h2, 8'h20}, {9'b110111111, 4'h4, 8'h54}, {9'b110100000, 4'h1, 8'h55}};
   assign {graceful_stop, restart_tx, rx_clock_glitch, tx_clock_glitch, rx_char_stored,
      rx_discard, rx_buffer_closed, enter_hunt} = pv;
   btf_tx_framer dut_u (.sys_clk, .rst, .ce(1'b1), .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
      .desc_ready, .desc_eom, .desc_send_check_after, .desc_continuous_reuse,
      .desc_check_accum_reset, .desc_prepend_escape, .desc_clear_channel_mode,
      .desc_check_include, .desc_length, .desc_take, .desc_close, .desc_keep_ready,
      .desc_starved_flag, .desc_send_permit_lost, .data_byte, .data_valid, .data_ready,
      .line_char, .line_valid, .line_ready, .cts, .sync_char(SYNC), .dle_char(DLE),
      .lrc_select, .idle_fill_select(idle_fill), .tx_check_preset(16'h0000), .graceful_stop,
      .restart_tx, .carrier_sense, .rx_clock_glitch, .tx_clock_glitch, .rx_char_stored,
      .rx_discard, .rx_buffer_closed, .enter_hunt, .rx_suspended, .irq);
   btf_line_station st_u (.sys_clk, .rst, .slow, .line_char, .line_valid, .line_ready);
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // Buffer memory restarts at every take, like a fresh buffer pointer
   always @(posedge sys_clk) begin
      if (desc_take === 1'b1) begin
         src_idx <= 1;
         data_byte <= src[0];
         data_valid <= 1'b1;
      end else if (data_valid && data_ready) begin
         src_idx <= src_idx + 1;
         data_byte <= src[src_idx[3:0]];
         data_valid <= src_idx < src_len;
      end
   end
   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic print_verdict;
      if (fails == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [1:0] a, input logic [15:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(reg_rdata, e);
   endtask : rd
   task automatic pulse(input logic [7:0] p);
      @(posedge sys_clk);
      pv <= p;
      @(posedge sys_clk);
      pv <= 8'h00;
   endtask : pulse
   function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
      c = c ^ {8'h00, b};
      for (int k = 0; k < 8; k++) begin
         c = c[0] ? ((c >> 1) ^ CRC16_POLY_REFL) : (c >> 1);
      end
      return c;
   endfunction : crc
   task automatic expect_row(input btf_row_t r);
      logic [7:0] b;
      if (r.br) acc = 16'h0000;
      if (r.td) exp_q.push_back(DLE);
      for (int i = 0; i < 32'(r.len); i++) begin
         b = r.b0 + 8'(i);
         exp_q.push_back(b);
         if (r.tr && b == DLE) exp_q.push_back(DLE);
         if (r.inc) acc = crc(acc, b);
      end
      if (r.tb) begin
         exp_q.push_back(acc[7:0]);
         exp_q.push_back(acc[15:8]);
         acc = 16'h0000;
      end else begin
         exp_q.push_back(SYNC);
         exp_q.push_back(SYNC);
      end
   endtask : expect_row
   task automatic run(input btf_row_t r, input logic [2:0] e);
      int t = 0;
      for (int i = 0; i < 16; i++) begin
         src[i] = r.b0 + 8'(i);
      end
      @(posedge sys_clk);
      {desc_eom, desc_send_check_after, desc_continuous_reuse, desc_check_accum_reset,
         desc_prepend_escape, desc_clear_channel_mode, desc_check_include, lrc_select,
         slow} <= r[20:12];
      src_len <= 32'(r.len);
      desc_length <= 16'(r.len);
      desc_ready <= 1'b1;
      do @(negedge sys_clk); while (desc_take !== 1'b1 && ++t < 300);
      st_u.got_q.delete();
      @(posedge sys_clk);
      desc_ready <= 1'b0;
      do @(negedge sys_clk); while (desc_close !== 1'b1 && ++t < 300);
      chk({13'h0, desc_keep_ready, desc_starved_flag, desc_send_permit_lost}, {13'h0, e});
      chk(16'(t >= 300), 16'h0000);
      repeat (20) @(posedge sys_clk);
   endtask : run
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      rst = 1'b1;
      {reg_wr, desc_ready, desc_eom, desc_send_check_after, desc_continuous_reuse} = '0;
      {desc_check_accum_reset, desc_prepend_escape, desc_clear_channel_mode} = '0;
      {desc_check_include, lrc_select, slow, carrier_sense, idle_fill} = '0;
      {reg_addr, reg_wdata, desc_length, pv, acc} = '0;
      {src_len, fails, n_checks} = '0;
      cts = 1'b1;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      rd(ADR_EVENT_FLAGS, EVENT_FLAGS_RST);
      rd(ADR_EVENT_ENABLES, EVENT_ENABLES_RST);
      wr(ADR_LINE_STATUS, 16'hFFFF);
      rd(ADR_LINE_STATUS, 16'h0000);
      rd(2'h3, 16'h0000);
      pulse(8'h3E);
      rd(ADR_EVENT_FLAGS, 16'h180D);
      chk({15'h0, rx_suspended}, 16'h0001);
      wr(ADR_EVENT_ENABLES, 16'hFFFF);
      rd(ADR_EVENT_ENABLES, EVENT_USED_MASK);
      wr(ADR_EVENT_FLAGS, 16'h1809);
      rd(ADR_EVENT_FLAGS, 16'h0004);
      chk({15'h0, irq}, 16'h0001);
      wr(ADR_EVENT_ENABLES, 16'h0004);
      // New event and its clear on one edge: the event must survive
      fork
         wr(ADR_EVENT_FLAGS, 16'h0004);
         pulse(8'h24);
      join
      rd(ADR_EVENT_FLAGS, 16'h1004);
      wr(ADR_EVENT_FLAGS, 16'h0004);
      @(negedge sys_clk);
      chk({15'h0, irq}, 16'h0000);
      pulse(8'h01);
      @(negedge sys_clk);
      chk({15'h0, rx_suspended}, 16'h0000);
      wr(ADR_EVENT_FLAGS, 16'hFFFF);
      @(posedge sys_clk);
      carrier_sense <= 1'b1;
      rd(ADR_LINE_STATUS, 16'h0001);
      rd(ADR_EVENT_FLAGS, 16'h0400);
      @(posedge sys_clk);
      carrier_sense <= 1'b0;
      rd(ADR_LINE_STATUS, 16'h0000);
      wr(ADR_EVENT_FLAGS, 16'hFFFF);
      pulse(8'h80);
      rd(ADR_EVENT_FLAGS, 16'h0080);
      @(posedge sys_clk);
      desc_ready <= 1'b1;
      repeat (4) @(negedge sys_clk);
      chk({15'h0, desc_take}, 16'h0000);
      @(posedge sys_clk);
      desc_ready <= 1'b0;
      pulse(8'h40);
      wr(ADR_EVENT_FLAGS, 16'hFFFF);
      foreach (rows[i]) begin
         expect_row(rows[i]);
         run(rows[i], {rows[i].cm, 2'b00});
         chk(16'(st_u.got_q.size()), 16'(exp_q.size()));
         foreach (exp_q[j]) chk({8'h00, st_u.got_q[j]}, {8'h00, exp_q[j]});
         exp_q.delete();
         rd(ADR_EVENT_FLAGS, 16'h0002);
         wr(ADR_EVENT_FLAGS, 16'h0002);
      end
      run({9'b001000000, 4'h2, 8'h60}, 3'b010);
      chk({8'h00, st_u.got_q[$]}, {8'h00, SYNC});
      chk({8'h00, st_u.got_q[$ - 1]}, {8'h00, SYNC});
      run({9'b001001000, 4'h2, 8'h60}, 3'b010);
      chk({8'h00, st_u.got_q[$] ^ st_u.got_q[$ - 1]}, {8'h00, SYNC ^ DLE});
      run({9'b100000000, 4'h1, 8'h70}, 3'b000);
      rd(ADR_EVENT_FLAGS, 16'h0012);
      wr(ADR_EVENT_FLAGS, 16'hFFFF);
      // Idle fill chosen: block end without check sends no sync pair
      @(posedge sys_clk);
      idle_fill <= 1'b1;
      run({9'b100000000, 4'h1, 8'h71}, 3'b000);
      chk(16'(st_u.got_q.size()), 16'h0001);
      idle_fill <= 1'b0;
      @(posedge sys_clk);
      cts <= 1'b0;
      run({9'b101100100, 4'h2, 8'h70}, 3'b001);
      cts <= 1'b1;
      rd(ADR_EVENT_FLAGS, 16'h0012);
      @(posedge sys_clk);
      rst <= 1'b1;
      @(posedge sys_clk);
      rst <= 1'b0;
      rd(ADR_EVENT_FLAGS, 16'h0000);
      rd(ADR_EVENT_ENABLES, 16'h0000);
      print_verdict();
   end
   // Whole run is a few hundred cycles; this leaves ample margin
   initial begin
      #(20 * 30000);
      fails++;
      print_verdict();
   end
endmodule : tb_top
